// ---- rtl/ext_mem_if.sv ----
`timescale 1ns/1ns
// ---------------------------------------------------------------------
// Overview of operation
// - at reset latch top five address pins as bank strap; disabled shadow forces 31
// - shadow strap high: copy flash into program SRAM after reset, run from it
// - shadow strap low: program fetches go straight to flash
// - clock strap high selects the PLL as system clock
// - clock strap low bypasses the PLL onto the crystal input, test use only
// - main data select low only for addresses 0x008000 through 0x207fff
// - expansion selects cover programmable regions inside 0x208000 through 0xbfffff
// - shared pin is expansion select three only with shadow and one bank
// - shadow mode drives flash select on flash accesses; otherwise flash select stays high and flash accesses drive program select
// - data read strobe low only during SRAM data reads and shadowed program fetches
// - after reset shadow strap pin becomes flash write strobe
// - after reset clock strap pin becomes flash read strobe
// ---------------------------------------------------------------------
module ext_mem_if #(
   parameter int BANK_BYTES = ext_mem_pkg::BANK_BYTES_DEFAULT
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_rstn,
   input  wire logic                   i_req,
   input  wire ext_mem_pkg::req_s      i_req_bus,
   input  wire ext_mem_pkg::window_s [2:0] i_exp_win,
   input  wire logic [4:0]             i_ext_addr_hi,
   input  wire logic [7:0]             i_ext_data_bus,
   input  wire logic                   i_nvm_write_strobe_n,
   input  wire logic                   i_nvm_read_strobe_n,
   output logic                        o_ready,
   output logic                        o_done,
   output logic [7:0]                  o_rdata,
   output logic [23:0]                 o_ext_addr_bus,
   output logic                        o_ext_addr_hi_oe,
   output logic [7:0]                  o_ext_data_bus,
   output logic                        o_ext_data_oe,
   output logic                        o_main_data_select_n,
   output logic                        o_expansion_select1_n,
   output logic                        o_expansion_select2_n,
   output logic                        o_program_mem_select_n,
   output logic                        o_data_write_strobe_n,
   output logic                        o_data_read_strobe_n,
   output logic                        o_nvm_select_n,
   output logic                        o_nvm_write_strobe_n,
   output logic                        o_nvm_write_strobe_oe,
   output logic                        o_nvm_read_strobe_n,
   output logic                        o_nvm_read_strobe_oe,
   output logic                        o_shadow_en,
   output logic                        o_use_pll,
   output logic [4:0]                  o_bank_code,
   output logic                        o_copying
);

   // -----------------------------------------------------------------
   // decode helpers
   // -----------------------------------------------------------------
   function automatic logic in_range(input logic [23:0] a,
                                     input logic [23:0] lo,
                                     input logic [23:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic strobe_on(input logic busy,
                                      input logic hit,
                                      input logic flash_acc,
                                      input logic write_acc,
                                      input logic want_flash,
                                      input logic want_write);
      strobe_on = busy && hit && (flash_acc == want_flash) && (write_acc == want_write);
   endfunction

   function automatic ext_mem_pkg::sel_s decode(input ext_mem_pkg::req_s r,
                                                input logic shadow,
                                                input logic exp3_mode,
                                                input ext_mem_pkg::window_s [2:0] w);
      ext_mem_pkg::sel_s s;
      logic              found;
      s     = '0;
      found = 1'b0;
      case (r.kind)
         ext_mem_pkg::KIND_NVM: begin
            // flash select only in shadow mode
            s.nvm  = shadow;
            s.prog = !shadow;
         end
         ext_mem_pkg::KIND_PROG: begin
            s.prog = 1'b1;
         end
         ext_mem_pkg::KIND_DATA: begin
            if (in_range(r.addr, ext_mem_pkg::MAIN_LO, ext_mem_pkg::MAIN_HI)) begin
               s.main = 1'b1;
            end else if (in_range(r.addr, ext_mem_pkg::EXP_LO, ext_mem_pkg::EXP_HI)) begin
               for (int i = 0; i < ext_mem_pkg::EXP_COUNT; i++) begin
                  if (!found && (i < 2 || exp3_mode) &&
                      in_range(r.addr, w[i].base, w[i].limit)) begin
                     s.exp[i] = 1'b1;
                     found    = 1'b1;
                  end
               end
            end
         end
         default: begin
            s = '0;
         end
      endcase
      decode = s;
   endfunction

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   ext_mem_pkg::state_e state;
   ext_mem_pkg::req_s   cur;
   ext_mem_pkg::sel_s   sel;
   logic [1:0]          cnt;
   logic [21:0]         ptr;
   logic [21:0]         copy_last;
   logic                shadow;
   logic [4:0]          bank;
   logic                exp3_mode;
   logic                active;
   logic                flash_cycle;
   logic                any_sel;
   logic                step_end;

   assign exp3_mode   = shadow && (bank == ext_mem_pkg::BANK_SINGLE);
   assign copy_last   = 22'((32'(bank) + 1) * BANK_BYTES - 1);
   assign step_end    = (cnt == ext_mem_pkg::ACC_END);
   assign active      = (state == ext_mem_pkg::ST_COPY_RD || state == ext_mem_pkg::ST_COPY_WR ||
                         state == ext_mem_pkg::ST_ACC) && !step_end;
   assign sel         = decode(cur, shadow, exp3_mode, i_exp_win);
   assign any_sel     = |sel;
   // flash strobes for flash accesses, and for program space without shadow
   assign flash_cycle = (cur.kind == ext_mem_pkg::KIND_NVM) ||
                        (cur.kind == ext_mem_pkg::KIND_PROG && !shadow);

   // -----------------------------------------------------------------
   // sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state   <= ext_mem_pkg::ST_STRAP;
         ptr     <= 22'h0;
         cur     <= '0;
         o_ready <= 1'b0;
         o_done  <= 1'b0;
         o_rdata <= 8'h00;
         o_copying <= 1'b0;
      end else begin
         o_done <= 1'b0;
         case (state)
            ext_mem_pkg::ST_STRAP: begin
               ptr <= 22'h0;
               cur <= '{kind: ext_mem_pkg::KIND_NVM, wr: 1'b0, addr: 24'h00_0000, wdata: 8'h00};
               if (i_nvm_write_strobe_n) begin
                  // shadow copy starts after the strap cycle
                  state     <= ext_mem_pkg::ST_COPY_RD;
                  o_copying <= 1'b1;
               end else begin
                  state   <= ext_mem_pkg::ST_IDLE;
                  o_ready <= 1'b1;
               end
            end
            ext_mem_pkg::ST_COPY_RD: begin
               if (step_end) begin
                  cur.kind  <= ext_mem_pkg::KIND_PROG;
                  cur.wr    <= 1'b1;
                  cur.wdata <= i_ext_data_bus;
                  state     <= ext_mem_pkg::ST_COPY_WR;
               end
            end
            ext_mem_pkg::ST_COPY_WR: begin
               if (step_end) begin
                  // copy every byte of the strapped banks
                  if (ptr == copy_last) begin
                     state     <= ext_mem_pkg::ST_IDLE;
                     o_ready   <= 1'b1;
                     o_copying <= 1'b0;
                  end else begin
                     ptr   <= ptr + 22'h1;
                     cur   <= '{kind: ext_mem_pkg::KIND_NVM, wr: 1'b0,
                                addr: 24'(ptr + 22'h1), wdata: 8'h00};
                     state <= ext_mem_pkg::ST_COPY_RD;
                  end
               end
            end
            ext_mem_pkg::ST_IDLE: begin
               if (i_req) begin
                  cur     <= i_req_bus;
                  o_ready <= 1'b0;
                  state   <= ext_mem_pkg::ST_ACC;
               end
            end
            ext_mem_pkg::ST_ACC: begin
               if (step_end) begin
                  o_done  <= 1'b1;
                  o_rdata <= cur.wr ? o_rdata : i_ext_data_bus;
                  o_ready <= 1'b1;
                  state   <= ext_mem_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= ext_mem_pkg::ST_STRAP;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // phase counter
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt <= 2'h0;
      end else begin
         cnt <= (state == ext_mem_pkg::ST_IDLE || state == ext_mem_pkg::ST_STRAP || step_end) ?
                2'h0 : cnt + 2'h1;
      end
   end

   // -----------------------------------------------------------------
   // strap capture
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         shadow                <= 1'b0;
         bank                  <= ext_mem_pkg::BANK_RESET;
         o_use_pll             <= 1'b0;
         o_ext_addr_hi_oe      <= 1'b0;
         o_nvm_write_strobe_oe <= 1'b0;
         o_nvm_read_strobe_oe  <= 1'b0;
      end else if (state == ext_mem_pkg::ST_STRAP) begin
         shadow    <= i_nvm_write_strobe_n;
         // bank strap, fixed when shadow is off
         bank      <= i_nvm_write_strobe_n ? i_ext_addr_hi : ext_mem_pkg::BANK_FIXED;
         o_use_pll <= i_nvm_read_strobe_n;
         o_ext_addr_hi_oe      <= 1'b1;
         o_nvm_write_strobe_oe <= 1'b1;
         o_nvm_read_strobe_oe  <= 1'b1;
      end
   end

   assign o_shadow_en = shadow;
   assign o_bank_code = bank;

   // -----------------------------------------------------------------
   // address and write data pins
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_ext_addr_bus <= 24'h00_0000;
         o_ext_data_bus <= 8'h00;
         o_ext_data_oe  <= 1'b0;
      end else begin
         o_ext_addr_bus <= cur.addr;
         o_ext_data_bus <= cur.wdata;
         o_ext_data_oe  <= active && cur.wr && any_sel;
      end
   end

   // -----------------------------------------------------------------
   // chip selects
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_main_data_select_n   <= 1'b1;
         o_expansion_select1_n  <= 1'b1;
         o_expansion_select2_n  <= 1'b1;
         o_program_mem_select_n <= 1'b1;
         o_nvm_select_n         <= 1'b1;
      end else begin
         o_main_data_select_n   <= !(active && sel.main);
         o_expansion_select1_n  <= !(active && sel.exp[0]);
         o_expansion_select2_n  <= !(active && sel.exp[1]);
         // shared pin as program select or expansion three
         o_program_mem_select_n <= !(active && (sel.prog || sel.exp[2]));
         o_nvm_select_n         <= !(active && sel.nvm);
      end
   end

   // -----------------------------------------------------------------
   // strobes
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_data_write_strobe_n <= 1'b1;
         o_data_read_strobe_n  <= 1'b1;
         o_nvm_write_strobe_n  <= 1'b1;
         o_nvm_read_strobe_n   <= 1'b1;
      end else begin
         o_data_write_strobe_n <= !strobe_on(active, any_sel, flash_cycle, cur.wr, 1'b0, 1'b1);
         o_data_read_strobe_n  <= !strobe_on(active, any_sel, flash_cycle, cur.wr, 1'b0, 1'b0);
         o_nvm_write_strobe_n  <= !strobe_on(active, any_sel, flash_cycle, cur.wr, 1'b1, 1'b1);
         o_nvm_read_strobe_n   <= !strobe_on(active, any_sel, flash_cycle, cur.wr, 1'b1, 1'b0);
      end
   end

endmodule // ext_mem_if

// ---- rtl/ext_mem_pkg.sv ----
package ext_mem_pkg;

   // -----------------------------------------------------------------
   // address windows
   // -----------------------------------------------------------------
   localparam logic [23:0] MAIN_LO = 24'h00_8000;
   localparam logic [23:0] MAIN_HI = 24'h20_7fff;
   localparam logic [23:0] EXP_LO  = 24'h20_8000;
   localparam logic [23:0] EXP_HI  = 24'hbf_ffff;

   // -----------------------------------------------------------------
   // straps
   // -----------------------------------------------------------------
   localparam int          ADDR_HI_LSB  = 19;
   localparam logic [4:0]  BANK_RESET   = 5'h00;
   localparam logic [4:0]  BANK_FIXED   = 5'h1f;
   localparam logic [4:0]  BANK_SINGLE  = 5'h00;
   localparam int          BANK_BYTES_DEFAULT = 65536;

   // -----------------------------------------------------------------
   // access timing
   // -----------------------------------------------------------------
   localparam logic [1:0]  ACC_END      = 2'h2;
   localparam int          EXP_COUNT    = 3;

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      KIND_DATA = 2'h0,
      KIND_PROG = 2'h1,
      KIND_NVM  = 2'h2
   } kind_e;

   typedef enum logic [4:0] {
      ST_STRAP   = 5'b00001,
      ST_COPY_RD = 5'b00010,
      ST_COPY_WR = 5'b00100,
      ST_IDLE    = 5'b01000,
      ST_ACC     = 5'b10000
   } state_e;

   typedef struct packed {
      logic [23:0] base;
      logic [23:0] limit;
   } window_s;

   typedef struct packed {
      kind_e       kind;
      logic        wr;
      logic [23:0] addr;
      logic [7:0]  wdata;
   } req_s;

   typedef struct packed {
      logic [2:0]  exp;
      logic        main;
      logic        prog;
      logic        nvm;
   } sel_s;

endpackage

// ---- verification/ext_mem_asserts.sv ----
`timescale 1ns/1ns
module ext_mem_asserts (
   input wire logic        i_clk,
   input wire logic        i_rstn,
   input wire logic        i_req,
   input wire logic        o_ready,
   input wire logic        o_done,
   input wire logic [23:0] o_ext_addr_bus,
   input wire logic        o_ext_data_oe,
   input wire logic        o_main_data_select_n,
   input wire logic        o_expansion_select1_n,
   input wire logic        o_expansion_select2_n,
   input wire logic        o_program_mem_select_n,
   input wire logic        o_nvm_select_n,
   input wire logic        o_data_write_strobe_n,
   input wire logic        o_data_read_strobe_n,
   input wire logic        o_nvm_write_strobe_oe,
   input wire logic        o_shadow_en,
   input wire logic [4:0]  o_bank_code,
   input wire logic        o_copying
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   AST_MAIN_WIN: assert property (!o_main_data_select_n |->
      o_ext_addr_bus inside {[ext_mem_pkg::MAIN_LO:ext_mem_pkg::MAIN_HI]}) else $error("main select off window");
   AST_EXP_WIN: assert property (!o_expansion_select1_n || !o_expansion_select2_n |->
      o_ext_addr_bus inside {[ext_mem_pkg::EXP_LO:ext_mem_pkg::EXP_HI]}) else $error("expansion off window");
   AST_ONE_SEL: assert property ($countones({~o_main_data_select_n, ~o_expansion_select1_n,
      ~o_expansion_select2_n, ~o_program_mem_select_n, ~o_nvm_select_n}) <= 1) else $error("two selects");
   AST_RD_LEN: assert property ($fell(o_data_read_strobe_n) |=> !o_data_read_strobe_n ##1 o_data_read_strobe_n)
      else $error("read strobe length");
   AST_WR_DATA: assert property (!o_data_write_strobe_n |-> o_ext_data_oe && o_data_read_strobe_n)
      else $error("write strobe without data");
   AST_NVM_SEL: assert property (!o_nvm_select_n |-> o_shadow_en) else $error("flash select unshadowed");
   AST_BANK: assert property (o_ready && !o_shadow_en |-> o_bank_code == ext_mem_pkg::BANK_FIXED)
      else $error("bank not fixed");
   AST_PINS_OUT: assert property (o_ready |-> o_nvm_write_strobe_oe && $stable(o_shadow_en))
      else $error("strap pin not output");
   AST_DONE: assert property (i_req && o_ready |-> ##4 o_done) else $error("done late");
   AST_COPY: assert property (o_copying |-> o_shadow_en && !o_ready) else $error("copy unshadowed");
endmodule // ext_mem_asserts

bind ext_mem_if ext_mem_asserts i_ext_mem_asserts (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req),
   .o_ready(o_ready), .o_done(o_done), .o_ext_addr_bus(o_ext_addr_bus), .o_ext_data_oe(o_ext_data_oe),
   .o_main_data_select_n(o_main_data_select_n), .o_expansion_select1_n(o_expansion_select1_n),
   .o_expansion_select2_n(o_expansion_select2_n), .o_program_mem_select_n(o_program_mem_select_n),
   .o_nvm_select_n(o_nvm_select_n), .o_data_write_strobe_n(o_data_write_strobe_n),
   .o_data_read_strobe_n(o_data_read_strobe_n), .o_nvm_write_strobe_oe(o_nvm_write_strobe_oe),
   .o_shadow_en(o_shadow_en), .o_bank_code(o_bank_code), .o_copying(o_copying));

// ---- verification/ext_mem_partner.sv ----
`timescale 1ns/1ns
module ext_mem_partner (
   input  wire logic        i_clk,
   input  wire logic [4:0]  i_pull_bank,
   input  wire logic        i_pull_shadow,
   input  wire logic        i_pull_clk,
   input  wire logic [23:0] i_addr,
   input  wire logic        i_addr_hi_oe,
   input  wire logic [7:0]  i_data,
   input  wire logic        i_data_oe,
   input  wire logic        i_data_rd_n,
   input  wire logic        i_nvm_rd_n,
   input  wire logic        i_nvm_rd_oe,
   input  wire logic        i_nvm_wr_n,
   input  wire logic        i_nvm_wr_oe,
   output logic [4:0]       o_addr_hi,
   output logic [7:0]       o_data,
   output logic             o_nvm_wr_n,
   output logic             o_nvm_rd_n
);
   logic [7:0] last = 8'h00;
   assign o_addr_hi = i_addr_hi_oe ? i_addr[23:19] : i_pull_bank;
   assign o_nvm_wr_n = i_nvm_wr_oe ? i_nvm_wr_n : i_pull_shadow;
   assign o_nvm_rd_n = i_nvm_rd_oe ? i_nvm_rd_n : i_pull_clk;
   // released bus toggles so a stale value never passes
   assign o_data = i_data_oe ? i_data : ((!i_data_rd_n || !i_nvm_rd_n) ? i_addr[7:0] ^ 8'ha5 : ~last);
   always @(posedge i_clk) last <= o_data;
endmodule // ext_mem_partner

// ---- verification/test_ext_mem_if.sv ----
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
module test_ext_mem_if;
   logic                       clk, rstn, req, pull_sh, pull_ck;
   logic [4:0]                 pull_bank;
   logic [8:0]                 seen;
   logic [7:0]                 wseen;
   logic [23:0]                aseen;
   ext_mem_pkg::req_s          req_bus;
   ext_mem_pkg::window_s [2:0] win;
   int                         fail_count, checks, cyc;
   wire  [4:0]                 addr_hi, bank;
   wire  [7:0]                 din, dout, rdata;
   wire  [23:0]                addr;
   wire                        nwr_in, nrd_in, ready, done, hi_oe, dout_oe, main_n, e1_n, e2_n, prog_n;
   wire                        dwr_n, drd_n, nsel_n, nwr_n, nwr_oe, nrd_n, nrd_oe, shadow, pll, copying;
   wire  [8:0]                 act = ~{main_n, e1_n, e2_n, prog_n, nsel_n, dwr_n, drd_n, nwr_n, nrd_n};

   ext_mem_if #(.BANK_BYTES(4)) i_ext_mem_if (.i_clk(clk), .i_rstn(rstn), .i_req(req), .i_req_bus(req_bus),
      .i_exp_win(win), .i_ext_addr_hi(addr_hi), .i_ext_data_bus(din), .i_nvm_write_strobe_n(nwr_in),
      .i_nvm_read_strobe_n(nrd_in), .o_ready(ready), .o_done(done), .o_rdata(rdata), .o_ext_addr_bus(addr),
      .o_ext_addr_hi_oe(hi_oe), .o_ext_data_bus(dout), .o_ext_data_oe(dout_oe), .o_main_data_select_n(main_n),
      .o_expansion_select1_n(e1_n), .o_expansion_select2_n(e2_n), .o_program_mem_select_n(prog_n),
      .o_data_write_strobe_n(dwr_n), .o_data_read_strobe_n(drd_n), .o_nvm_select_n(nsel_n),
      .o_nvm_write_strobe_n(nwr_n), .o_nvm_write_strobe_oe(nwr_oe), .o_nvm_read_strobe_n(nrd_n),
      .o_nvm_read_strobe_oe(nrd_oe), .o_shadow_en(shadow), .o_use_pll(pll), .o_bank_code(bank),
      .o_copying(copying));
   ext_mem_partner i_ext_mem_partner (.i_clk(clk), .i_pull_bank(pull_bank), .i_pull_shadow(pull_sh),
      .i_pull_clk(pull_ck), .i_addr(addr), .i_addr_hi_oe(hi_oe), .i_data(dout), .i_data_oe(dout_oe),
      .i_data_rd_n(drd_n), .i_nvm_rd_n(nrd_n), .i_nvm_rd_oe(nrd_oe), .i_nvm_wr_n(nwr_n), .i_nvm_wr_oe(nwr_oe),
      .o_addr_hi(addr_hi), .o_data(din), .o_nvm_wr_n(nwr_in), .o_nvm_rd_n(nrd_in));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // pin activity since the last request or reset
   always @(posedge clk) begin
      seen <= (req || !rstn) ? 9'h000 : seen | act;
      if (req || !rstn) begin
         wseen <= 8'h00;
         aseen <= 24'h00_0000;
      end else begin
         if ((!dwr_n || !nwr_n) && dout_oe) wseen <= dout;
         if (act != 9'h000) aseen <= addr;
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic rst(input logic sh, input logic ck, input logic [4:0] bk);
      pull_sh = sh;
      pull_ck = ck;
      pull_bank = bk;
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      while (ready !== 1'b1) @(negedge clk);
   endtask

   task automatic acc(input ext_mem_pkg::kind_e k, input logic wr, input logic [23:0] a, input logic [8:0] e);
      @(negedge clk);
      req_bus = '{kind: k, wr: wr, addr: a, wdata: a[7:0] ^ 8'h3c};
      req = 1'b1;
      @(negedge clk);
      req = 1'b0;
      while (done !== 1'b1) @(negedge clk);
      `CHK(seen, e)
      if (!wr && e != 9'h000) `CHK(rdata, a[7:0] ^ 8'ha5)
      if (wr && e != 9'h000) `CHK(wseen, a[7:0] ^ 8'h3c)
      if (e != 9'h000) `CHK(aseen, a)
   endtask

   initial begin
      rstn = 1'b0;
      req = 1'b0;
      req_bus = '0;
      win[0] = '{base: 24'h20_8000, limit: 24'h20_80ff};
      win[1] = '{base: 24'h30_0000, limit: 24'h30_00ff};
      win[2] = '{base: 24'hbf_ff00, limit: 24'hbf_ffff};
      rst(1'b0, 1'b1, 5'h03);
      `CHK(({shadow, pll, bank, seen}), ({2'h1, 5'h1f, 9'h000}))
      `CHK(({hi_oe, nwr_oe, nrd_oe}), (3'h7))
      acc(ext_mem_pkg::KIND_DATA, 1'b0, 24'h00_8000, 9'h104);
      acc(ext_mem_pkg::KIND_DATA, 1'b1, 24'h20_7fff, 9'h108);
      acc(ext_mem_pkg::KIND_DATA, 1'b0, 24'h00_7fff, 9'h000);
      acc(ext_mem_pkg::KIND_DATA, 1'b0, 24'h20_8000, 9'h084);
      acc(ext_mem_pkg::KIND_DATA, 1'b1, 24'h30_00ff, 9'h048);
      acc(ext_mem_pkg::KIND_DATA, 1'b0, 24'hbf_ff00, 9'h000);
      acc(ext_mem_pkg::KIND_PROG, 1'b0, 24'h01_2345, 9'h021);
      acc(ext_mem_pkg::KIND_NVM, 1'b1, 24'h01_0000, 9'h022);
      $display("test straps off done");
      rst(1'b1, 1'b0, 5'h00);
      `CHK(({shadow, pll, bank, seen}), ({2'h2, 5'h00, 9'h039}))
      `CHK(({nwr_oe, nrd_oe, wseen, aseen}), ({2'h3, 8'ha6, 24'h00_0003}))
      acc(ext_mem_pkg::KIND_DATA, 1'b0, 24'hbf_ff00, 9'h024);
      acc(ext_mem_pkg::KIND_NVM, 1'b0, 24'h00_1234, 9'h011);
      acc(ext_mem_pkg::KIND_PROG, 1'b1, 24'h00_0042, 9'h028);
      $display("test single bank shadow done");
      rst(1'b1, 1'b1, 5'h02);
      `CHK(({shadow, pll, bank}), ({2'h3, 5'h02}))
      `CHK(({wseen, aseen}), ({8'hae, 24'h00_000b}))
      acc(ext_mem_pkg::KIND_DATA, 1'b0, 24'hbf_ff00, 9'h000);
      acc(ext_mem_pkg::KIND_PROG, 1'b0, 24'h00_0100, 9'h024);
      $display("test multi bank shadow done");
      end_sim();
   end
endmodule // test_ext_mem_if
